// [design/brs_pkg.sv]
// Constants, encodings and types for the brown-out reset sequencer.
// Assumes a 20 MHz APB clock and one oscillator period per pclk cycle.
package brs_pkg;

	// Clock rate and timer width
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned TMR_W = 16;

	// Oscillator settle time in oscillator periods, one period per pclk
	localparam int unsigned SETTLE_TOSC = 1024;
	localparam int unsigned SETTLE_CYC = SETTLE_TOSC;

	// Power-up delay and clock-monitor delay in microseconds
	localparam int unsigned PUD_US = 400;
	localparam int unsigned FSCM_US = 500;
	localparam int unsigned PUD_CYC = PUD_US * CLK_MHZ;
	localparam int unsigned FSCM_CYC = FSCM_US * CLK_MHZ;

	// Register byte addresses
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_CAUSE = 8'h04;
	localparam logic [7:0] ADDR_OSC = 8'h08;
	localparam logic [7:0] ADDR_ISTS = 8'h0c;
	localparam logic [7:0] ADDR_IMSK = 8'h10;

	// Field positions
	localparam int unsigned CFG_SEL_LSB = 0;
	localparam int unsigned CFG_MODE_LSB = 4;
	localparam int unsigned CFG_PUD_BIT = 8;
	localparam int unsigned CAUSE_DIP_BIT = 1;
	localparam int unsigned OSC_LOCK_BIT = 5;
	localparam int unsigned OSC_CUR_LSB = 12;
	localparam int unsigned IRQ_DIP_BIT = 0;
	localparam int unsigned IRQ_REL_BIT = 1;
	localparam int unsigned IRQ_N = 2;

	// Reset values of configuration fields
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic [1:0] MODE_RST = 2'h3;
	localparam logic PUD_RST = 1'b1;

	// Oscillator select encodings
	localparam logic [2:0] SEL_FRC = 3'h0;
	localparam logic [2:0] SEL_FRC_PLL = 3'h1;
	localparam logic [2:0] SEL_PRI = 3'h2;
	localparam logic [2:0] SEL_PRI_PLL = 3'h3;

	// Primary oscillator mode encodings
	localparam logic [1:0] MODE_EC = 2'h0;
	localparam logic [1:0] MODE_XT = 2'h1;
	localparam logic [1:0] MODE_HS = 2'h2;
	localparam logic [1:0] MODE_OFF = 2'h3;

	// Sequencer states
	typedef enum logic [1:0] {
		BRS_HOLD,
		BRS_WAIT,
		BRS_RUN
	} brs_state_e;

endpackage

// [design/brs_tmr_if.sv]
// Start, load and done of one delay timer.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface brs_tmr_if #(parameter int W = 16) ();
	logic start;
	logic [W-1:0] load;
	logic done;
	modport ctl (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

// [design/brs_delay_timer.sv]
// Down-counting delay timer, loaded by a start pulse.
// Assumes start is a one-cycle pulse on pclk; done is stale on that cycle.
`timescale 1ns/1ps
`default_nettype none
module brs_delay_timer #(
	parameter int W = 16
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Control
	brs_tmr_if.tmr tif
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic run;
	} brs_tmr_s;

	brs_tmr_s s_q;
	brs_tmr_s s_d;

	// Load on start, then count down to zero
	always_comb begin
		s_d = s_q;
		if (tif.start) begin
			s_d.cnt = tif.load;
			s_d.run = 1'b1;
		end else if (s_q.run && s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Expired once the count reaches zero
	assign tif.done = s_q.run && (s_q.cnt == '0);

endmodule
`default_nettype wire

// [design/brs_seq.sv]
// Brown-out reset sequencer with APB registers and one interrupt line.
// Assumes brownout_det and pll_lock arrive asynchronously from analog.
//
// Notes on behaviour
// (R1) A detected supply dip drives a reset pulse to the whole device.
// (R2) After a dip, clock source follows oscillator select and primary mode.
// (R3) Oscillator selected: clock gated until 1024 oscillator periods elapse.
// (R4) PLL selected: clock gated until the PLL lock flag reads one.
// (R5) Power-up delay runs in parallel; reset released only after it.
// (R6) Zero power-up delay with crystal: only clock-monitor delay applies.
// (R7) A supply-dip reset sets the dip flag in the reset-cause register.
// (R8) Dip detection and reset stay active in Sleep and Idle.
// (R9) Dip flag survives its reset; only a software zero write clears it.
// (R10) Analog dip level is synchronised before it starts the sequence.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module brs_seq #(
	parameter logic [brs_pkg::TMR_W-1:0] PUD_CYC =
		brs_pkg::TMR_W'(brs_pkg::PUD_CYC),
	parameter logic [brs_pkg::TMR_W-1:0] FSCM_CYC =
		brs_pkg::TMR_W'(brs_pkg::FSCM_CYC)
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [brs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog monitor and PLL
	input wire logic brownout_det,
	input wire logic pll_lock,
	// Device reset and clock control
	output logic dev_reset_n,
	output logic sysclk_en,
	output logic [2:0] cur_osc_sel,
	// Interrupt
	output logic irq
);

	typedef struct packed {
		logic bo_s1;
		logic bo_s2;
		logic lk_s1;
		logic lk_s2;
		brs_pkg::brs_state_e st;
		logic [2:0] new_osc_select;
		logic [1:0] primary_osc_mode;
		logic pud_en;
		logic [2:0] act_sel;
		logic osc_use;
		logic pll_use;
		logic settle_go;
		logic dly_go;
		logic [brs_pkg::TMR_W-1:0] dly_load;
		logic flag_dip;
		logic [brs_pkg::IRQ_N-1:0] irq_sts;
		logic [brs_pkg::IRQ_N-1:0] irq_msk;
		logic rst_n;
		logic clk_en;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} brs_seq_s;

	brs_seq_s s_q;
	brs_seq_s s_d;

	brs_tmr_if #(.W(brs_pkg::TMR_W)) settle_if ();
	brs_tmr_if #(.W(brs_pkg::TMR_W)) dly_if ();

	// Oscillator settle timer and power-up delay timer
	brs_delay_timer #(.W(brs_pkg::TMR_W)) u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tif(settle_if.tmr)
	);
	brs_delay_timer #(.W(brs_pkg::TMR_W)) u_dly (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tif(dly_if.tmr)
	);

	assign settle_if.start = s_q.settle_go;
	assign settle_if.load = brs_pkg::TMR_W'(brs_pkg::SETTLE_CYC); // R3
	assign dly_if.start = s_q.dly_go;
	assign dly_if.load = s_q.dly_load;

	// Clock source decoded from configuration fields
	logic sel_pri;
	logic sel_osc;
	logic sel_pll;
	logic sel_xtal;
	assign sel_pri = (s_q.new_osc_select == brs_pkg::SEL_PRI) ||
		(s_q.new_osc_select == brs_pkg::SEL_PRI_PLL);
	assign sel_osc = sel_pri &&
		(s_q.primary_osc_mode != brs_pkg::MODE_OFF); // R2
	assign sel_pll = (s_q.new_osc_select == brs_pkg::SEL_FRC_PLL) ||
		(s_q.new_osc_select == brs_pkg::SEL_PRI_PLL); // R2
	assign sel_xtal = sel_osc &&
		((s_q.primary_osc_mode == brs_pkg::MODE_XT) ||
		(s_q.primary_osc_mode == brs_pkg::MODE_HS));

	// APB phase decode
	logic apb_setup;
	logic apb_done;
	logic apb_wr;
	logic cause_clr;
	assign apb_setup = psel && !penable;
	assign apb_done = psel && penable && s_q.pready;
	assign apb_wr = apb_done && pwrite;
	assign cause_clr = apb_wr && (paddr == brs_pkg::ADDR_CAUSE) &&
		!pwdata[brs_pkg::CAUSE_DIP_BIT];

	// Clock and reset release conditions while waiting
	logic clk_ok;
	logic rel_ok;
	assign clk_ok = !s_q.settle_go &&
		(!s_q.osc_use || settle_if.done) && // R3
		(!s_q.pll_use || s_q.lk_s2); // R4
	assign rel_ok = clk_ok && !s_q.dly_go && dly_if.done; // R5

	// Next state of the whole block
	always_comb begin
		s_d = s_q;
		s_d.bo_s1 = brownout_det; // R10
		s_d.bo_s2 = s_q.bo_s1; // R10
		s_d.lk_s1 = pll_lock;
		s_d.lk_s2 = s_q.lk_s1;
		s_d.settle_go = 1'b0;
		s_d.dly_go = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;

		// Register read in the setup cycle, no wait state
		if (apb_setup) begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			case (paddr)
				brs_pkg::ADDR_CFG: begin
					s_d.prdata[brs_pkg::CFG_SEL_LSB +: 3] = s_q.new_osc_select;
					s_d.prdata[brs_pkg::CFG_MODE_LSB +: 2] =
						s_q.primary_osc_mode;
					s_d.prdata[brs_pkg::CFG_PUD_BIT] = s_q.pud_en;
				end
				brs_pkg::ADDR_CAUSE: begin
					s_d.prdata[brs_pkg::CAUSE_DIP_BIT] = s_q.flag_dip;
				end
				brs_pkg::ADDR_OSC: begin
					s_d.prdata[brs_pkg::OSC_LOCK_BIT] = s_q.lk_s2; // R4
					s_d.prdata[brs_pkg::OSC_CUR_LSB +: 3] = s_q.act_sel;
				end
				brs_pkg::ADDR_ISTS: begin
					s_d.prdata[brs_pkg::IRQ_N-1:0] = s_q.irq_sts;
				end
				brs_pkg::ADDR_IMSK: begin
					s_d.prdata[brs_pkg::IRQ_N-1:0] = s_q.irq_msk;
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
		end

		// Register writes at the completing edge
		if (apb_wr) begin
			case (paddr)
				brs_pkg::ADDR_CFG: begin
					s_d.new_osc_select = pwdata[brs_pkg::CFG_SEL_LSB +: 3];
					s_d.primary_osc_mode = pwdata[brs_pkg::CFG_MODE_LSB +: 2];
					s_d.pud_en = pwdata[brs_pkg::CFG_PUD_BIT];
				end
				brs_pkg::ADDR_IMSK: begin
					s_d.irq_msk = pwdata[brs_pkg::IRQ_N-1:0];
				end
				default: begin
				end
			endcase
		end
		if (cause_clr) begin
			s_d.flag_dip = 1'b0; // R9
		end

		// Status read clears only the bits that were returned
		if (apb_done && !pwrite && paddr == brs_pkg::ADDR_ISTS) begin
			s_d.irq_sts = s_q.irq_sts & ~s_q.prdata[brs_pkg::IRQ_N-1:0];
		end

		// Reset sequence
		case (s_q.st)
			brs_pkg::BRS_HOLD: begin
				s_d.rst_n = 1'b0; // R1
				s_d.clk_en = 1'b0;
				if (!s_q.bo_s2) begin
					s_d.act_sel = s_q.new_osc_select; // R2
					s_d.osc_use = sel_osc; // R3
					s_d.pll_use = sel_pll; // R4
					if (s_q.pud_en) begin
						s_d.dly_load = PUD_CYC; // R5
					end else if (sel_xtal) begin
						s_d.dly_load = FSCM_CYC; // R6
					end else begin
						s_d.dly_load = '0;
					end
					s_d.settle_go = 1'b1;
					s_d.dly_go = 1'b1; // R5
					s_d.st = brs_pkg::BRS_WAIT;
				end
			end
			brs_pkg::BRS_WAIT: begin
				s_d.clk_en = clk_ok; // R3 R4
				if (rel_ok) begin
					s_d.rst_n = 1'b1; // R5
					s_d.irq_sts[brs_pkg::IRQ_REL_BIT] = 1'b1;
					s_d.st = brs_pkg::BRS_RUN;
				end
			end
			brs_pkg::BRS_RUN: begin
			end
			default: begin
				s_d.st = brs_pkg::BRS_HOLD;
			end
		endcase

		// Dip acts in every state while ce is high; set wins over clear
		if (s_q.bo_s2) begin
			s_d.st = brs_pkg::BRS_HOLD; // R8
			s_d.rst_n = 1'b0; // R1
			s_d.clk_en = 1'b0;
			s_d.flag_dip = 1'b1; // R7
			s_d.irq_sts[brs_pkg::IRQ_DIP_BIT] = 1'b1;
		end

		s_d.irq = |(s_d.irq_sts & s_d.irq_msk);
	end

	// State register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.new_osc_select <= brs_pkg::SEL_RST;
			s_q.primary_osc_mode <= brs_pkg::MODE_RST;
			s_q.pud_en <= brs_pkg::PUD_RST;
			s_q.st <= brs_pkg::BRS_HOLD;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign dev_reset_n = s_q.rst_n;
	assign sysclk_en = s_q.clk_en;
	assign cur_osc_sel = s_q.act_sel;
	assign irq = s_q.irq;

	// Checks on the sequence
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_dip_resets_dev: assert property ( // R1
		(ce && s_q.bo_s2) |=> (!dev_reset_n && !sysclk_en))
		else $error("dip did not reset the device");

	a_clock_choice: assert property ( // R2
		(ce && s_q.st == brs_pkg::BRS_HOLD && !s_q.bo_s2) |=>
		(cur_osc_sel == $past(s_q.new_osc_select) &&
		s_q.pll_use == $past(sel_pll)))
		else $error("clock source not taken from configuration");

	a_settle_gate: assert property ( // R3
		(ce && s_q.st == brs_pkg::BRS_WAIT && s_q.osc_use &&
		!settle_if.done && !s_q.bo_s2) |=> !sysclk_en)
		else $error("clock released before settle timer expired");

	a_pll_gate: assert property ( // R4
		(ce && s_q.pll_use && !s_q.lk_s2) |=> !sysclk_en)
		else $error("clock released without PLL lock");

	a_release_delay: assert property ( // R5
		$rose(dev_reset_n) |-> ($past(dly_if.done) && $past(clk_ok)))
		else $error("reset released before power-up delay");

	a_fscm_only: assert property ( // R6
		(ce && s_q.st == brs_pkg::BRS_HOLD && !s_q.bo_s2 &&
		!s_q.pud_en && sel_xtal) |=> (s_q.dly_load == FSCM_CYC))
		else $error("clock-monitor delay not applied");

	a_dip_flag_set: assert property ( // R7
		(ce && s_q.bo_s2) |=> s_q.flag_dip)
		else $error("dip flag not set");

	a_dip_any_state: assert property ( // R8
		(ce && s_q.bo_s2 && s_q.st != brs_pkg::BRS_HOLD) |=>
		(s_q.st == brs_pkg::BRS_HOLD))
		else $error("dip ignored outside hold");

	a_flag_sticky: assert property ( // R9
		(s_q.flag_dip && !(ce && cause_clr)) |=> s_q.flag_dip)
		else $error("dip flag lost without software clear");

	a_sync_two: assert property ( // R10
		($past(ce) && $past(ce, 2)) |-> (s_q.bo_s2 == $past(brownout_det, 2)))
		else $error("dip level not passed through two flops");

	a_apb_wait: assert property (
		(ce && apb_setup) |=> pready)
		else $error("no ready in access phase");

	c_full_release: cover property ($rose(dev_reset_n));
	c_fscm_path: cover property (
		s_q.dly_go && s_q.dly_load == FSCM_CYC);
	c_pll_wait: cover property (
		s_q.st == brs_pkg::BRS_WAIT && s_q.pll_use && !s_q.lk_s2);
	c_dip_in_wait: cover property (
		s_q.st == brs_pkg::BRS_WAIT && s_q.bo_s2);

endmodule
`default_nettype wire

// [tb/brs_analog_model.sv]
// Supply monitor and PLL seen from the sequencer.
// Assumes the bench raises dip_req for a dip; PLL relocks after lock_dly.
`timescale 1ns/1ps
`default_nettype none
module brs_analog_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic dip_req,
	input wire logic [11:0] lock_dly,
	// Analog levels
	output logic brownout_det,
	output logic pll_lock
);
	logic [11:0] cnt_q;
	// Lock lost during a dip, regained after lock_dly cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= 12'h000;
		else if (dip_req)
			cnt_q <= 12'h000;
		else if (cnt_q < lock_dly)
			cnt_q <= cnt_q + 12'h001;
	end
	// Plain levels, not tied to pclk in the real part
	assign brownout_det = dip_req;
	assign pll_lock = (cnt_q >= lock_dly) && !dip_req;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the brown-out reset sequencer.
// Assumes APB answers when ready; delays shortened by parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int PW = 20;
	localparam int FS = 1200;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic dip_req, brownout_det, pll_lock, dev_reset_n, sysclk_en, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [2:0] cur_osc_sel;
	logic [11:0] lock_dly;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;

	brs_seq #(.PUD_CYC(16'(PW)), .FSCM_CYC(16'(FS))) dut_u (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .brownout_det(brownout_det),
		.pll_lock(pll_lock), .dev_reset_n(dev_reset_n),
		.sysclk_en(sysclk_en), .cur_osc_sel(cur_osc_sel), .irq(irq));
	brs_analog_model pm_u (.pclk(pclk), .presetn(presetn),
		.dip_req(dip_req), .lock_dly(lock_dly),
		.brownout_det(brownout_det), .pll_lock(pll_lock));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			results();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, held until pready
	task automatic apb(input int wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= (wr != 0);
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No timeout of its own; the hang guard ends it if pready never comes
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Dip for hold plus one cycles, then count cycles to reset release
	task automatic dip(input int hold);
		@(posedge pclk);
		dip_req <= 1'b1;
		@(posedge pclk);
		chk("reset before sync", 32'h1, 32'(dev_reset_n));
		repeat (hold) @(posedge pclk);
		chk("reset in dip", 32'h0, 32'(dev_reset_n));
		chk("clock gated", 32'h0, 32'(sysclk_en));
		dip_req <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (dev_reset_n !== 1'b1 && n < 3000);
		chk("clock on", 32'h1, 32'(sysclk_en));
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, dip_req} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lock_dly = 12'h010;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		while (dev_reset_n !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		chk("power-up release", 32'h1, 32'(n >= PW && n <= PW + 8));
		chk("power-up clock", 32'h1, 32'(sysclk_en));
		apb(0, 8'h00, 0);
		chk("cfg reset", 32'h130, r);
		apb(0, 8'h04, 0);
		chk("cause after power-up", 32'h0, r);
		apb(0, 8'h14, 0);
		chk("unmapped err", 32'h1, 32'(err));
		$display("test registers done");
		// FRC, power-up delay only
		apb(1, 8'h10, 32'h1);
		dip(8);
		chk("power-up delay", 32'h1, 32'(n >= PW && n <= PW + 8));
		chk("irq on dip", 32'h1, 32'(irq));
		apb(0, 8'h04, 0);
		chk("dip flag", 32'h2, r);
		apb(0, 8'h0c, 0);
		chk("status", 32'h3, r);
		@(posedge pclk);
		chk("irq cleared", 32'h0, 32'(irq));
		apb(1, 8'h04, 32'h2);
		apb(0, 8'h04, 0);
		chk("flag kept", 32'h2, r);
		apb(1, 8'h04, 32'h0);
		apb(0, 8'h04, 0);
		chk("flag cleared", 32'h0, r);
		$display("test dip done");
		// Primary XT: settle timer
		apb(1, 8'h00, 32'h112);
		dip(8);
		chk("settle", 32'h1, 32'(n >= 1024 && n <= 1040));
		chk("source", 32'h2, 32'(cur_osc_sel));
		apb(0, 8'h08, 0);
		chk("active sel", 32'h2, (r >> 12) & 32'h7);
		// Primary HS with PLL, slow lock
		lock_dly <= 12'd1500;
		apb(1, 8'h00, 32'h123);
		dip(8);
		chk("lock wait", 32'h1, 32'(n >= 1500 && n <= 1520));
		apb(0, 8'h08, 0);
		chk("lock bit", 32'h1, (r >> 5) & 32'h1);
		$display("test clock sources done");
		// FRC with PLL, no power-up delay, interrupt masked
		lock_dly <= 12'd40;
		apb(1, 8'h10, 32'h0);
		apb(1, 8'h00, 32'h031);
		dip(8);
		chk("frc pll", 32'h1, 32'(n >= 40 && n <= 60));
		chk("source", 32'h1, 32'(cur_osc_sel));
		chk("irq masked", 32'h0, 32'(irq));
		// Crystal without power-up delay: clock-monitor delay; then FRC with no delay
		apb(1, 8'h00, 32'h012);
		dip(8);
		chk("monitor delay", 32'h1, 32'(n >= FS && n <= FS + 8));
		apb(1, 8'h00, 32'h030);
		dip(8);
		chk("no delay", 32'h1, 32'(n <= 8));
		$display("test delays done");
		results();
	end
endmodule
`default_nettype wire
